// file: epc_pkg.sv
// package: register map, field positions and reset values of the encoder position counter
package epc_pkg;
  // byte addresses on the 32-bit register bus, one aligned word each
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_POS_LOW = 8'h08;
  localparam logic [7:0] ADDR_POS_HIGH = 8'h0C;
  localparam logic [7:0] ADDR_POS_HOLD = 8'h10;
  localparam logic [7:0] ADDR_VEL = 8'h14;
  localparam logic [7:0] ADDR_IDX_LOW = 8'h18;
  localparam logic [7:0] ADDR_IDX_HIGH = 8'h1C;
  localparam logic [7:0] ADDR_ICAP_LOW = 8'h20;
  localparam logic [7:0] ADDR_ICAP_HIGH = 8'h24;
  localparam logic [7:0] ADDR_LEC_HIGH = 8'h28;
  localparam logic [7:0] ADDR_LEC_LOW = 8'h2C;
  localparam logic [7:0] ADDR_GEC_HIGH = 8'h30;
  localparam logic [7:0] ADDR_GEC_LOW = 8'h34;
  localparam logic [7:0] ADDR_ITMR_HIGH = 8'h38;
  localparam logic [7:0] ADDR_ITMR_LOW = 8'h3C;
  localparam logic [7:0] ADDR_IHLD_HIGH = 8'h40;
  localparam logic [7:0] ADDR_IHLD_LOW = 8'h44;
  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GATE_EN_BIT = 2;
  localparam int CTRL_POL_BIT = 3;
  // status register fields
  localparam int STAT_OVF_IRQ_BIT = 9;
  localparam int STAT_OVF_IEN_BIT = 8;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [31:0] POS_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] POS_MIN = 32'h80000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    EPC_MODE_QUAD,
    EPC_MODE_EXT_UPDN,
    EPC_MODE_EXT_GATE,
    EPC_MODE_TIMER
  } epc_mode_t;
endpackage

// file: epc_top.sv
// encoder position counter: input decode, counters and AXI4-Lite register slave
//
// Overview of operation
// - position count is 32 bits, seen as low and high 16-bit words.
// - reading the low word copies the high word into the hold register.
// - write hold first; writing low word loads all 32 bits at once.
// - overflow flag set on 7FFFFFFF/80000000 rollover; interrupt when enabled.
// - two-bit mode field selects one of four counting modes.
// - quadrature mode decodes phases into count and direction for position and velocity.
// - quadrature mode counts valid index edges in the index counter.
// - up/down mode: phase A counts, phase B gives direction.
// - up/down mode direction positive while phase B is high, polarity bit inverts it.
// - gate mode: gate enabled and gate low suppresses counting.
// - gate mode: gate disabled counts regardless of gate level.
// - gate mode counts up, down when polarity bit is set.
// - initialisation/capture value: two writable 16-bit words, reset zero.
// - less-or-equal threshold: two read/write words, reset zero.
// - greater-or-equal threshold: two read/write words, reset zero.
// - interval timer: two read/write words, reset zero.
// - interval hold: two words, reset zero.
// - hold register is 16-bit read/write staging word for the high word.
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/10ps
module epc_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic phase_a_count_input,
  input wire logic phase_b_dir_gate_input,
  input wire logic index_input,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic position_overflow_irq
);
  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  logic [2:0] sa_r, sb_r, si_r;
  logic a_st_r, b_st_r, i_st_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sa_r <= 3'h0;
      sb_r <= 3'h0;
      si_r <= 3'h0;
    end else begin
      sa_r <= {sa_r[1:0], phase_a_count_input};
      sb_r <= {sb_r[1:0], phase_b_dir_gate_input};
      si_r <= {si_r[1:0], index_input};
    end
  end
  // a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!resetn) begin
      a_st_r <= 1'b0;
      b_st_r <= 1'b0;
      i_st_r <= 1'b0;
    end else begin
      if (sa_r[1] == sa_r[2]) a_st_r <= sa_r[2];
      if (sb_r[1] == sb_r[2]) b_st_r <= sb_r[2];
      if (si_r[1] == si_r[2]) i_st_r <= si_r[2];
    end
  end
  logic a_new, b_new, i_new;
  assign a_new = (sa_r[1] == sa_r[2]) ? sa_r[2] : a_st_r;
  assign b_new = (sb_r[1] == sb_r[2]) ? sb_r[2] : b_st_r;
  assign i_new = (si_r[1] == si_r[2]) ? si_r[2] : i_st_r;

  // ***************************************************************
  // control register and count source selection
  // ***************************************************************
  logic [15:0] ctrl_r;
  epc_pkg::epc_mode_t mode;
  logic gate_en, pol;
  assign mode = epc_pkg::epc_mode_t'(ctrl_r[epc_pkg::CTRL_MODE_LSB +: 2]);
  assign gate_en = ctrl_r[epc_pkg::CTRL_GATE_EN_BIT];
  assign pol = ctrl_r[epc_pkg::CTRL_POL_BIT];

  logic cnt_pulse, cnt_up;
  logic quad_pulse, quad_up;
  logic gate_open;
  // quadrature: one change of either phase is a count; both at once is invalid
  assign quad_pulse = (a_new ^ a_st_r) ^ (b_new ^ b_st_r);
  // new A against old B: up when phase A leads phase B
  assign quad_up = (a_new ^ b_st_r);
  assign gate_open = !gate_en || b_st_r;
  always_comb begin
    cnt_pulse = 1'b0;
    cnt_up = 1'b1;
    case (mode)
      epc_pkg::EPC_MODE_QUAD: begin
        cnt_pulse = quad_pulse;
        cnt_up = quad_up;
      end
      epc_pkg::EPC_MODE_EXT_UPDN: begin
        cnt_pulse = a_new && !a_st_r;
        cnt_up = b_st_r ^ pol;
      end
      epc_pkg::EPC_MODE_EXT_GATE: begin
        cnt_pulse = a_new && !a_st_r && gate_open;
        cnt_up = !pol;
      end
      epc_pkg::EPC_MODE_TIMER: begin
        // clock division is not provided: one count per cycle
        cnt_pulse = gate_open;
        cnt_up = !pol;
      end
      default: begin
        cnt_pulse = 1'b0;
        cnt_up = 1'b1;
      end
    endcase
  end
  logic idx_pulse;
  assign idx_pulse = (mode == epc_pkg::EPC_MODE_QUAD) && i_new && !i_st_r;

  // ***************************************************************
  // bus slave handshake
  // ***************************************************************
  logic [7:0] awaddr_r;
  logic aw_have_r, w_have_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go, rd_go;
  assign wr_go = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  logic wr_hit;
  // every aligned word from the control word up to the last hold word is mapped
  assign wr_hit = (awaddr_r <= epc_pkg::ADDR_IHLD_LOW) && (awaddr_r[1:0] == 2'h0);
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= epc_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_r <= s_axi_awaddr;
        aw_have_r <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_have_r <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? epc_pkg::RESP_OKAY : epc_pkg::RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // low 16 bits merged under the byte strobes; upper lanes are ignored
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  logic wr_pos_low, wr_pos_high, wr_hold, rd_pos_low, rd_vel;
  assign wr_pos_low = wr_go && awaddr_r == epc_pkg::ADDR_POS_LOW;
  assign wr_pos_high = wr_go && awaddr_r == epc_pkg::ADDR_POS_HIGH;
  assign wr_hold = wr_go && awaddr_r == epc_pkg::ADDR_POS_HOLD;
  assign rd_pos_low = rd_go && s_axi_araddr == epc_pkg::ADDR_POS_LOW;
  assign rd_vel = rd_go && s_axi_araddr == epc_pkg::ADDR_VEL;

  // ***************************************************************
  // plain storage words
  // ***************************************************************
  logic [15:0] icap_l_r, icap_h_r, lec_h_r, lec_l_r, gec_h_r, gec_l_r;
  logic [15:0] itmr_h_r, itmr_l_r, ihld_h_r, ihld_l_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_r <= epc_pkg::WORD_RESET;
      icap_l_r <= epc_pkg::WORD_RESET;
      icap_h_r <= epc_pkg::WORD_RESET;
      lec_h_r <= epc_pkg::WORD_RESET;
      lec_l_r <= epc_pkg::WORD_RESET;
      gec_h_r <= epc_pkg::WORD_RESET;
      gec_l_r <= epc_pkg::WORD_RESET;
      ihld_h_r <= epc_pkg::WORD_RESET;
      ihld_l_r <= epc_pkg::WORD_RESET;
    end else if (wr_go) begin
      case (awaddr_r)
        epc_pkg::ADDR_CTRL: ctrl_r <= merge16(ctrl_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_ICAP_LOW: icap_l_r <= merge16(icap_l_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_ICAP_HIGH: icap_h_r <= merge16(icap_h_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_LEC_HIGH: lec_h_r <= merge16(lec_h_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_LEC_LOW: lec_l_r <= merge16(lec_l_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_GEC_HIGH: gec_h_r <= merge16(gec_h_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_GEC_LOW: gec_l_r <= merge16(gec_l_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_IHLD_HIGH: ihld_h_r <= merge16(ihld_h_r, wdata_r, wstrb_r);
        epc_pkg::ADDR_IHLD_LOW: ihld_l_r <= merge16(ihld_l_r, wdata_r, wstrb_r);
        default: ctrl_r <= ctrl_r;
      endcase
    end
  end
  // interval timer words are plain storage; measuring between pulses is not provided
  always_ff @(posedge clk) begin
    if (!resetn) begin
      itmr_h_r <= epc_pkg::WORD_RESET;
      itmr_l_r <= epc_pkg::WORD_RESET;
    end else if (wr_go && awaddr_r == epc_pkg::ADDR_ITMR_HIGH) begin
      itmr_h_r <= merge16(itmr_h_r, wdata_r, wstrb_r);
    end else if (wr_go && awaddr_r == epc_pkg::ADDR_ITMR_LOW) begin
      itmr_l_r <= merge16(itmr_l_r, wdata_r, wstrb_r);
    end
  end

  // ***************************************************************
  // position, hold, velocity and index counters
  // ***************************************************************
  logic [31:0] pos_r, pos_nxt, idx_r;
  logic [15:0] hold_r, vel_r;
  always_comb begin
    pos_nxt = pos_r;
    if (cnt_pulse) pos_nxt = cnt_up ? pos_r + 32'h00000001 : pos_r - 32'h00000001;
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pos_r <= 32'h00000000;
    end else if (wr_pos_low) begin
      // hold and low word enter together, one coherent load
      pos_r <= {hold_r, merge16(pos_r[15:0], wdata_r, wstrb_r)};
    end else if (wr_pos_high) begin
      pos_r <= {merge16(pos_r[31:16], wdata_r, wstrb_r), pos_r[15:0]};
    end else begin
      pos_r <= pos_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hold_r <= epc_pkg::WORD_RESET;
    end else if (rd_pos_low) begin
      hold_r <= pos_r[31:16];
    end else if (wr_hold) begin
      hold_r <= merge16(hold_r, wdata_r, wstrb_r);
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vel_r <= epc_pkg::WORD_RESET;
    end else if (rd_vel) begin
      vel_r <= epc_pkg::WORD_RESET;
    end else if (cnt_pulse && mode == epc_pkg::EPC_MODE_QUAD) begin
      vel_r <= cnt_up ? vel_r + 16'h0001 : vel_r - 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      idx_r <= 32'h00000000;
    end else if (idx_pulse) begin
      idx_r <= quad_up ? idx_r + 32'h00000001 : idx_r - 32'h00000001;
    end
  end

  // ***************************************************************
  // overflow status and interrupt
  // ***************************************************************
  logic ovf_evt, ovf_flag_r, ovf_ien_r;
  assign ovf_evt = !wr_pos_low && !wr_pos_high && cnt_pulse &&
                   ((pos_r == epc_pkg::POS_MAX && cnt_up) ||
                    (pos_r == epc_pkg::POS_MIN && !cnt_up));
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ovf_flag_r <= 1'b0;
      ovf_ien_r <= 1'b0;
    end else begin
      if (wr_go && awaddr_r == epc_pkg::ADDR_STAT) begin
        ovf_ien_r <= wdata_r[epc_pkg::STAT_OVF_IEN_BIT];
        // writing zero clears the flag; a coincident event wins
        if (!wdata_r[epc_pkg::STAT_OVF_IRQ_BIT]) ovf_flag_r <= 1'b0;
      end
      if (ovf_evt) ovf_flag_r <= 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) position_overflow_irq <= 1'b0;
    else position_overflow_irq <= ovf_flag_r && ovf_ien_r;
  end

  // ***************************************************************
  // read channel
  // ***************************************************************
  logic [15:0] rd_word;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      epc_pkg::ADDR_CTRL: rd_word = ctrl_r;
      epc_pkg::ADDR_STAT: rd_word = {6'h00, ovf_flag_r, ovf_ien_r, 8'h00};
      epc_pkg::ADDR_POS_LOW: rd_word = pos_r[15:0];
      epc_pkg::ADDR_POS_HIGH: rd_word = pos_r[31:16];
      epc_pkg::ADDR_POS_HOLD: rd_word = hold_r;
      epc_pkg::ADDR_VEL: rd_word = vel_r;
      epc_pkg::ADDR_IDX_LOW: rd_word = idx_r[15:0];
      epc_pkg::ADDR_IDX_HIGH: rd_word = idx_r[31:16];
      epc_pkg::ADDR_ICAP_LOW: rd_word = icap_l_r;
      epc_pkg::ADDR_ICAP_HIGH: rd_word = icap_h_r;
      epc_pkg::ADDR_LEC_HIGH: rd_word = lec_h_r;
      epc_pkg::ADDR_LEC_LOW: rd_word = lec_l_r;
      epc_pkg::ADDR_GEC_HIGH: rd_word = gec_h_r;
      epc_pkg::ADDR_GEC_LOW: rd_word = gec_l_r;
      epc_pkg::ADDR_ITMR_HIGH: rd_word = itmr_h_r;
      epc_pkg::ADDR_ITMR_LOW: rd_word = itmr_l_r;
      epc_pkg::ADDR_IHLD_HIGH: rd_word = ihld_h_r;
      epc_pkg::ADDR_IHLD_LOW: rd_word = ihld_l_r;
      default: begin
        rd_word = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= epc_pkg::RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? epc_pkg::RESP_OKAY : epc_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_hold_copy;
    @(posedge clk) disable iff (!resetn)
    rd_pos_low |=> hold_r == $past(pos_r[31:16]);
  endproperty
  a_hold_copy: assert property (p_hold_copy) else $error("hold not loaded on low read");
  property p_coherent_load;
    @(posedge clk) disable iff (!resetn)
    wr_pos_low |=> pos_r[31:16] == $past(hold_r);
  endproperty
  a_coherent_load: assert property (p_coherent_load) else $error("high word not from hold");
  sequence s_flag_then_irq;
    ovf_flag_r ##1 (position_overflow_irq == ovf_ien_r);
  endsequence
  property p_ovf_set;
    @(posedge clk) disable iff (!resetn)
    ovf_evt |=> s_flag_then_irq;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag or irq wrong");
  property p_gate_block;
    @(posedge clk) disable iff (!resetn)
    (mode == epc_pkg::EPC_MODE_EXT_GATE && gate_en && !b_st_r && !wr_pos_low && !wr_pos_high)
      |=> pos_r == $past(pos_r);
  endproperty
  a_gate_block: assert property (p_gate_block) else $error("gated count moved");
  property p_updn_dir;
    @(posedge clk) disable iff (!resetn)
    (mode == epc_pkg::EPC_MODE_EXT_UPDN && cnt_pulse && !wr_pos_low && !wr_pos_high)
      |=> pos_r == $past(pos_r) + (($past(b_st_r) ^ $past(pol)) ? 32'h1 : 32'hFFFFFFFF);
  endproperty
  a_updn_dir: assert property (p_updn_dir) else $error("up/down direction wrong");
  property p_gate_dir;
    @(posedge clk) disable iff (!resetn)
    (mode == epc_pkg::EPC_MODE_EXT_GATE && cnt_pulse && !pol && !wr_pos_low && !wr_pos_high)
      |=> pos_r == $past(pos_r) + 32'h1;
  endproperty
  a_gate_dir: assert property (p_gate_dir) else $error("gate mode not counting up");
  property p_idx_only_quad;
    @(posedge clk) disable iff (!resetn)
    (mode != epc_pkg::EPC_MODE_QUAD) |=> idx_r == $past(idx_r);
  endproperty
  a_idx_only_quad: assert property (p_idx_only_quad) else $error("index moved");
  property p_rd_answer;
    @(posedge clk) disable iff (!resetn)
    rd_go |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
endmodule

// file: epc_encoder_model.sv
// encoder and pulse source model driving the phase, direction/gate and index pins
`timescale 1ns/10ps
module epc_encoder_model (
  input wire logic clk,
  output logic phase_a,
  output logic phase_b,
  output logic index
);
  initial begin
    phase_a = 1'b0;
    phase_b = 1'b0;
    index = 1'b0;
  end
  // each level stands long enough to pass the pin synchroniser and reach the counter
  task automatic drive(input logic a, input logic b, input logic i);
    @(posedge clk);
    phase_a <= a;
    phase_b <= b;
    index <= i;
    repeat (10) @(posedge clk);
  endtask
endmodule

// file: encoder_position_counter_bench.sv
// self-checking bench for the encoder position counter
`timescale 1ns/10ps
module encoder_position_counter_bench;
  logic clk = 1'b0, resetn = 1'b0, qa, qb, qi, irq;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  // answer readies stay up, so back-to-back calls never toggle them within one step
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 32'h00000000, rdata, seed = 32'h90BDDB51, exp_pos;
  logic [1:0] bresp, rresp;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int mismatches = 0, n_checks = 0;
  always #2 clk = ~clk;
  epc_encoder_model epc_encoder_model_i (.clk(clk), .phase_a(qa), .phase_b(qb), .index(qi));
  epc_top epc_top_i (.clk(clk), .resetn(resetn), .phase_a_count_input(qa),
    .phase_b_dir_gate_input(qb), .index_input(qi), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .position_overflow_irq(irq));
  // ****************************************************************
  // checking helpers and bus cycles
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [33:0] seen, input logic [33:0] expv);
    n_checks++;
    if (seen !== expv) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // results are compared in arrival order against the notes left by the bus tasks
  always @(posedge clk) begin
    if (bvalid && bready)
      chk("write response", {32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      chk("read data", {rresp, rdata}, rq.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    bq.push_back(er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    rq.push_back({er, ed});
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
  endtask
  // low word first so the hold register captures the matching high word
  task automatic rdpos(input logic [31:0] p);
    rd(epc_pkg::ADDR_POS_LOW, {16'h0000, p[15:0]}, epc_pkg::RESP_OKAY);
    rd(epc_pkg::ADDR_POS_HOLD, {16'h0000, p[31:16]}, epc_pkg::RESP_OKAY);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test();
  end
  // ****************************************************************
  // scenarios
  // ****************************************************************
  logic [7:0] regs[11] = '{epc_pkg::ADDR_ICAP_LOW, epc_pkg::ADDR_ICAP_HIGH,
    epc_pkg::ADDR_LEC_HIGH, epc_pkg::ADDR_LEC_LOW, epc_pkg::ADDR_GEC_HIGH,
    epc_pkg::ADDR_GEC_LOW, epc_pkg::ADDR_ITMR_HIGH, epc_pkg::ADDR_ITMR_LOW,
    epc_pkg::ADDR_IHLD_HIGH, epc_pkg::ADDR_IHLD_LOW, epc_pkg::ADDR_POS_HOLD};
  // mode, gate enable, polarity, phase b level; pins are set before the mode changes
  // quadrature entries step phase B first; pol has no effect there
  logic [4:0] cfg[12] = '{5'h01, 5'h00, 5'h03, 5'h02, 5'h14, 5'h15, 5'h10, 5'h13, 5'h09,
    5'h08, 5'h0A, 5'h1C};
  int dl[12] = '{-1, 1, -1, 1, 0, 1, 1, -1, 1, -1, 1, 0};
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(epc_pkg::ADDR_CTRL, 32'h0, epc_pkg::RESP_OKAY);
    foreach (regs[k]) begin
      rd(regs[k], 32'h0, epc_pkg::RESP_OKAY);
      seed = lfsr(seed);
      wr(regs[k], seed, epc_pkg::RESP_OKAY);
      rd(regs[k], {16'h0000, seed[15:0]}, epc_pkg::RESP_OKAY);
    end
    wr(8'h48, 32'h1, epc_pkg::RESP_SLVERR);
    rd(8'h48, 32'h0, epc_pkg::RESP_SLVERR);
    $display("test registers done");
    wr(epc_pkg::ADDR_POS_HOLD, 32'h7FFF, epc_pkg::RESP_OKAY);
    wr(epc_pkg::ADDR_POS_LOW, 32'hFFFF, epc_pkg::RESP_OKAY);
    wr(epc_pkg::ADDR_POS_HOLD, 32'h1234, epc_pkg::RESP_OKAY);
    rdpos(32'h7FFFFFFF);
    $display("test coherent load done");
    wr(epc_pkg::ADDR_STAT, 32'h100, epc_pkg::RESP_OKAY);
    epc_encoder_model_i.drive(1'b1, 1'b0, 1'b0);
    chk("overflow irq", {33'h0, irq}, 34'h1);
    rd(epc_pkg::ADDR_STAT, 32'h300, epc_pkg::RESP_OKAY);
    rdpos(32'h80000000);
    rd(epc_pkg::ADDR_VEL, 32'h1, epc_pkg::RESP_OKAY);
    epc_encoder_model_i.drive(1'b1, 1'b0, 1'b1);
    epc_encoder_model_i.drive(1'b1, 1'b0, 1'b0);
    rd(epc_pkg::ADDR_IDX_LOW, 32'h1, epc_pkg::RESP_OKAY);
    epc_encoder_model_i.drive(1'b0, 1'b0, 1'b0);
    rdpos(32'h7FFFFFFF);
    wr(epc_pkg::ADDR_STAT, 32'h100, epc_pkg::RESP_OKAY);
    repeat (3) @(posedge clk);
    chk("cleared irq", {33'h0, irq}, 34'h0);
    $display("test quadrature done");
    exp_pos = 32'h7FFFFFFF;
    foreach (cfg[k]) begin
      epc_encoder_model_i.drive(1'b0, cfg[k][0], 1'b0);
      wr(epc_pkg::ADDR_CTRL, {28'h0, cfg[k][1], cfg[k][2], cfg[k][4:3]}, epc_pkg::RESP_OKAY);
      epc_encoder_model_i.drive(1'b1, cfg[k][0], 1'b0);
      epc_encoder_model_i.drive(1'b0, cfg[k][0], 1'b0);
      exp_pos = exp_pos + 32'(dl[k]);
      rdpos(exp_pos);
    end
    rdpos(exp_pos);
    $display("test count modes done");
    end_of_test();
  end
endmodule
